// ### ctx_continuous_tx.sv
// Continuous transmission test mode of the radio transceiver core.
// Assumes software on an 8-bit register port and RF test equipment on the output.
// Functional notes
// R1: Test mode transmits frame or carrier nonstop
// R2: Carrier sits half megahertz above or below
// R3: No carrier exactly on channel centre
// R4: Skip headers, send payload bytes repeated forever
// R5: Software loads valid payload, length first
// R6: Software makes length match stored bytes
// R7: Software configures channel, power, mode first
// R8: Ordered unlock: test control, then two ID writes
// R9: Software forces off state and verifies it
// R10: Software commands synthesizer on, then transmit start
// R11: Lock interrupt only; wait before transmit start
// R12: Software sets high rate only for carrier
// R13: Zeros give lower, ones upper carrier
// R14: Software prefers maximum length random frame
// R15: Software disables automatic checksum beforehand
// R16: Writing zero to ID leaves test mode
`timescale 1ns/1ps
module ctx_continuous_tx
  import ctx_pkg::*;
#(
  parameter logic [7:0] PART_ID_VALUE = 8'hA5 // Arbitrary identification value
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WE,
  input wire logic RE,
  output logic [7:0] RDATA,
  // Interrupt
  output logic IRQ,
  // Transmitter output
  output logic TX_ACTIVE,
  output logic TX_BIT,
  output logic TX_BIT_STROBE,
  output logic TX_CW,
  output logic TX_CW_UPPER,
  output logic [7:0] TX_CHANNEL,
  output logic [7:0] TX_POWER,
  output logic TEST_MODE
);

  typedef struct packed {
    ctx_state_type st;
    logic [1:0] unlock;
    logic test;
    logic [7:0] tst_ctrl;
    logic [7:0] tx_ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] chan;
    logic [7:0] pwr;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic [7:0] rdata;
    logic [7:0] lock_cnt;
    logic [6:0] idx;
    logic last;
    logic cw;
    logic cw_upper;
  } ctx_regs_type;

  ctx_regs_type q, d;
  logic [7:0] fb_mem [0:CTX_FB_DEPTH-1];
  logic [7:0] fb_rd;
  logic [7:0] next_byte;
  logic [6:0] frame_len;
  logic take;
  logic pace_run;
  logic wr_state;
  logic wr_part;
  logic [1:0] irq_set;
  logic [4:0] state_code;
  logic cw_sel;
  logic fill_byte;

  // Address decode shortcuts
  assign wr_state = WE && (ADDR == CTX_ADDR_STATE_COMMAND);
  assign wr_part = WE && (ADDR == CTX_ADDR_PART_ID);

  // Frame buffer: software writes at 0x80..0xFF
  always_ff @(posedge CLK) begin
    if (WE && ADDR[CTX_FB_BIT]) begin
      fb_mem[ADDR[6:0]] <= WDATA;
    end
  end

  assign fb_rd = fb_mem[ADDR[6:0]];
  assign next_byte = fb_mem[q.idx];
  // A zero length is treated as one byte so the loop never stalls
  assign frame_len = (fb_mem[0][6:0] == 7'h00) ? 7'h01 : fb_mem[0][6:0];

  // Carrier mode is chosen by the high rate setting
  assign cw_sel = (q.ctrl2[1:0] == CTX_RATE_HIGH);
  assign fill_byte = (next_byte == CTX_FILL_LOW) || (next_byte == CTX_FILL_HIGH);

  // State report encoding
  always_comb begin
    case (q.st)
      CTX_ST_OFF: state_code = CTX_RPT_OFF;
      CTX_ST_PLL_ON: state_code = CTX_RPT_PLL_ON;
      CTX_ST_BUSY_TX: state_code = CTX_RPT_BUSY_TX;
      default: state_code = CTX_RPT_TRANSITION;
    endcase
  end

  // Bit pacer runs while transmitting
  assign pace_run = (q.st == CTX_ST_BUSY_TX);

  ctx_bit_pacer u_pacer (
    .clk(CLK),
    .resetn(RESETN),
    .run(pace_run),
    .rate_sel(q.ctrl2[1:0]),
    .next_byte(next_byte),
    .take(take),
    .bit_out(TX_BIT),
    .bit_strobe(TX_BIT_STROBE)
  );

  // Next-state logic for all control state
  always_comb begin
    d = q;
    irq_set = 2'b00;

    // Register writes
    if (WE) begin
      case (ADDR)
        CTX_ADDR_TX_CONTROL_ONE: d.tx_ctrl1 = WDATA;
        CTX_ADDR_OUTPUT_POWER: d.pwr = WDATA;
        CTX_ADDR_CHANNEL_SELECT: d.chan = WDATA;
        CTX_ADDR_TRX_CONTROL_TWO: d.ctrl2 = WDATA;
        CTX_ADDR_IRQ_MASK: d.irq_mask = WDATA[1:0];
        default: d.tx_ctrl1 = q.tx_ctrl1;
      endcase
    end

    // Unlock sequence: test control, then two identification writes
    if (WE && (ADDR == CTX_ADDR_TEST_CONTROL)) begin
      d.tst_ctrl = WDATA;
      d.unlock = (WDATA == CTX_UNLOCK_STEP1) ? 2'h1 : 2'h0; // [R8]
    end
    if (wr_part) begin
      d.unlock = 2'h0;
      if (WDATA == CTX_TEST_EXIT) begin
        d.test = 1'b0; // [R16]
      end else if (WDATA == CTX_UNLOCK_STEP2 && q.unlock == 2'h1) begin
        d.unlock = 2'h2; // [R8]
      end else if (WDATA == CTX_UNLOCK_STEP3 && q.unlock == 2'h2) begin
        d.test = 1'b1; // [R8]
      end
    end

    // Transceiver state machine
    case (q.st)
      CTX_ST_OFF: begin
        if (wr_state && WDATA[4:0] == CTX_CMD_PLL_ON) begin
          d.st = CTX_ST_PLL_WAIT;
          d.lock_cnt = 8'h00;
        end
      end
      CTX_ST_PLL_WAIT: begin
        if (q.lock_cnt == 8'(CTX_LOCK_CYCLES - 1)) begin
          d.st = CTX_ST_PLL_ON;
          irq_set[CTX_IRQ_PLL_LOCK] = 1'b1; // [R11]
        end else begin
          d.lock_cnt = q.lock_cnt + 8'h01;
        end
      end
      CTX_ST_PLL_ON: begin
        // Transmit start is honoured only once the synthesizer is locked
        if (wr_state && WDATA[4:0] == CTX_CMD_TX_START) begin
          d.st = CTX_ST_BUSY_TX; // [R11]
          // Test mode skips the length byte; normal frames start with it
          d.idx = q.test ? 7'h01 : 7'h00; // [R4]
          d.last = 1'b0;
        end
      end
      CTX_ST_BUSY_TX: begin
        if (take) begin
          // Track the carrier offset from each byte taken
          d.cw = q.test && cw_sel && fill_byte; // [R13]
          d.cw_upper = (next_byte == CTX_FILL_HIGH); // [R2] [R3]
          if (q.test) begin
            // Payload loops forever; header never sent
            d.idx = (q.idx >= frame_len) ? 7'h01 : q.idx + 7'h01; // [R1] [R4]
          end else if (q.last) begin
            d.st = CTX_ST_PLL_ON;
            irq_set[CTX_IRQ_TX_END] = 1'b1;
          end else begin
            d.last = (q.idx >= frame_len);
            d.idx = q.idx + 7'h01;
          end
        end
      end
      default: d.st = CTX_ST_OFF;
    endcase

    // Off command overrides every state
    if (wr_state && WDATA[4:0] == CTX_CMD_OFF) begin
      d.st = CTX_ST_OFF;
    end
    if (d.st != CTX_ST_BUSY_TX) begin
      d.cw = 1'b0;
    end

    // Sticky interrupt flags: set wins over write-one-to-clear
    if (WE && ADDR == CTX_ADDR_IRQ_STATUS) begin
      d.irq_st = q.irq_st & ~WDATA[1:0];
    end
    d.irq_st = d.irq_st | irq_set;

    // Read data, one cycle after the strobe
    d.rdata = 8'h00;
    if (RE) begin
      if (ADDR[CTX_FB_BIT]) begin
        d.rdata = fb_rd;
      end else begin
        case (ADDR)
          CTX_ADDR_STATE_REPORT: d.rdata = {3'h0, state_code};
          CTX_ADDR_TX_CONTROL_ONE: d.rdata = q.tx_ctrl1;
          CTX_ADDR_OUTPUT_POWER: d.rdata = q.pwr;
          CTX_ADDR_CHANNEL_SELECT: d.rdata = q.chan;
          CTX_ADDR_TRX_CONTROL_TWO: d.rdata = q.ctrl2;
          CTX_ADDR_IRQ_MASK: d.rdata = {6'h00, q.irq_mask};
          CTX_ADDR_IRQ_STATUS: d.rdata = {6'h00, q.irq_st};
          CTX_ADDR_PART_ID: d.rdata = PART_ID_VALUE;
          CTX_ADDR_TEST_CONTROL: d.rdata = q.tst_ctrl;
          default: d.rdata = 8'h00;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      q <= '0;
      q.st <= CTX_ST_OFF;
      q.tx_ctrl1 <= CTX_RST_TX_CONTROL_ONE;
      q.chan <= CTX_RST_CHANNEL;
      q.pwr <= CTX_RST_ZERO;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign RDATA = q.rdata;
  assign IRQ = |(q.irq_st & q.irq_mask);
  assign TX_ACTIVE = (q.st == CTX_ST_BUSY_TX);
  assign TX_CW = q.cw;
  assign TX_CW_UPPER = q.cw_upper;
  assign TX_CHANNEL = q.chan;
  assign TX_POWER = q.pwr;
  assign TEST_MODE = q.test;

  // Checks on the documented behaviour
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  chk_tx_nonstop: assert property ( // [R1]
    (q.test && q.st == CTX_ST_BUSY_TX && !wr_state) |=> q.st == CTX_ST_BUSY_TX)
    else $error("test transmission stopped on its own");

  chk_carrier_side: assert property ( // [R2]
    (TX_CW && $changed(TX_CW_UPPER)) |-> $past(take))
    else $error("carrier side changed without a new byte");

  chk_no_centre: assert property ( // [R3]
    (q.st == CTX_ST_BUSY_TX && take && !fill_byte) |=> !TX_CW)
    else $error("carrier emitted for a modulated byte");

  chk_skip_header: assert property ( // [R4]
    (q.test && q.st == CTX_ST_BUSY_TX) |-> q.idx != 7'h00)
    else $error("length byte transmitted in test mode");

  chk_payload_wrap: assert property ( // [R4]
    (q.test && q.st == CTX_ST_BUSY_TX && take && q.idx >= frame_len && !wr_state)
    |=> q.idx == 7'h01)
    else $error("payload did not restart at first byte");

  chk_unlock_order: assert property ( // [R8]
    (!q.test && wr_part && WDATA == CTX_UNLOCK_STEP3 && q.unlock != 2'h2) |=> !q.test)
    else $error("test mode entered out of order");

  chk_unlock_done: assert property ( // [R8]
    (wr_part && WDATA == CTX_UNLOCK_STEP3 && q.unlock == 2'h2) |=> q.test)
    else $error("complete unlock did not enter test mode");

  chk_lock_event: assert property ( // [R11]
    (q.st == CTX_ST_OFF && wr_state && WDATA[4:0] == CTX_CMD_PLL_ON)
    |=> q.st == CTX_ST_PLL_WAIT [*8] ##[1:120] q.irq_st[CTX_IRQ_PLL_LOCK])
    else $error("lock event not raised in time");

  chk_start_gate: assert property ( // [R11]
    (q.st != CTX_ST_PLL_ON && q.st != CTX_ST_BUSY_TX) |=> q.st != CTX_ST_BUSY_TX)
    else $error("transmit started without lock");

  chk_lower_carrier: assert property ( // [R13]
    (q.test && cw_sel && take && q.st == CTX_ST_BUSY_TX && next_byte == CTX_FILL_LOW
     && !wr_state) |=> TX_CW && !TX_CW_UPPER)
    else $error("zero byte did not give lower carrier");

  chk_test_exit: assert property ( // [R16]
    (wr_part && WDATA == CTX_TEST_EXIT) |=> !q.test)
    else $error("test mode not left on zero write");

  // Lock flag must be raised even if software clears status in the same cycle
  chk_lock_set: assert property ( // [R11]
    (q.st == CTX_ST_PLL_WAIT && q.lock_cnt == 8'(CTX_LOCK_CYCLES - 1) && !wr_state)
    |=> q.st == CTX_ST_PLL_ON && q.irq_st[CTX_IRQ_PLL_LOCK])
    else $error("lock flag lost at end of settling");

  // All-ones payload gives the carrier above the channel centre
  chk_upper_carrier: assert property ( // [R13]
    (q.test && cw_sel && take && q.st == CTX_ST_BUSY_TX && next_byte == CTX_FILL_HIGH
     && !wr_state) |=> TX_CW && TX_CW_UPPER)
    else $error("ones byte did not give upper carrier");

  // Inside the payload the byte index steps by one per byte taken
  chk_payload_step: assert property ( // [R4]
    (q.test && q.st == CTX_ST_BUSY_TX && take && q.idx < frame_len && !wr_state)
    |=> q.idx == $past(q.idx) + 7'h01)
    else $error("payload byte skipped or repeated");

  cov_test_entry: cover property (wr_part && WDATA == CTX_UNLOCK_STEP3 && q.unlock == 2'h2);
  cov_lower: cover property (TX_CW && !TX_CW_UPPER);
  cov_test_tx: cover property (q.test && q.st == CTX_ST_BUSY_TX && take);
  cov_upper: cover property (TX_CW && TX_CW_UPPER);
  cov_lock_irq: cover property (IRQ);

endmodule

// ### ctx_pkg.sv
// Constants and types shared by the continuous transmission test block.
// Assumes a single 10 MHz clock and an 8-bit register port.
package ctx_pkg;

  // Clock and timing
  localparam int CTX_CLK_HZ = 10_000_000;
  localparam int CTX_LOCK_TIME_NS = 11_000;
  localparam int CTX_CLK_PERIOD_NS = 1_000_000_000 / CTX_CLK_HZ;
  localparam int CTX_LOCK_CYCLES = (CTX_LOCK_TIME_NS + CTX_CLK_PERIOD_NS - 1) / CTX_CLK_PERIOD_NS;

  // Bit periods for the four data rates
  localparam int CTX_RATE0_HZ = 250_000;
  localparam int CTX_RATE1_HZ = 500_000;
  localparam int CTX_RATE2_HZ = 1_000_000;
  localparam int CTX_RATE3_HZ = 2_000_000;
  localparam logic [5:0] CTX_BIT_CYC0 = 6'(CTX_CLK_HZ / CTX_RATE0_HZ);
  localparam logic [5:0] CTX_BIT_CYC1 = 6'(CTX_CLK_HZ / CTX_RATE1_HZ);
  localparam logic [5:0] CTX_BIT_CYC2 = 6'(CTX_CLK_HZ / CTX_RATE2_HZ);
  localparam logic [5:0] CTX_BIT_CYC3 = 6'(CTX_CLK_HZ / CTX_RATE3_HZ);

  // Register offsets
  localparam logic [7:0] CTX_ADDR_STATE_REPORT = 8'h01;
  localparam logic [7:0] CTX_ADDR_STATE_COMMAND = 8'h02;
  localparam logic [7:0] CTX_ADDR_TX_CONTROL_ONE = 8'h04;
  localparam logic [7:0] CTX_ADDR_OUTPUT_POWER = 8'h05;
  localparam logic [7:0] CTX_ADDR_CHANNEL_SELECT = 8'h08;
  localparam logic [7:0] CTX_ADDR_TRX_CONTROL_TWO = 8'h0C;
  localparam logic [7:0] CTX_ADDR_IRQ_MASK = 8'h0E;
  localparam logic [7:0] CTX_ADDR_IRQ_STATUS = 8'h0F;
  localparam logic [7:0] CTX_ADDR_PART_ID = 8'h1C;
  localparam logic [7:0] CTX_ADDR_TEST_CONTROL = 8'h36;
  localparam int CTX_FB_BIT = 7;
  localparam int CTX_FB_DEPTH = 128;

  // Reset values
  localparam logic [7:0] CTX_RST_TX_CONTROL_ONE = 8'h20;
  localparam logic [7:0] CTX_RST_CHANNEL = 8'h2B;
  localparam logic [7:0] CTX_RST_ZERO = 8'h00;

  // Unlock and exit values
  localparam logic [7:0] CTX_UNLOCK_STEP1 = 8'h0F;
  localparam logic [7:0] CTX_UNLOCK_STEP2 = 8'h54;
  localparam logic [7:0] CTX_UNLOCK_STEP3 = 8'h46;
  localparam logic [7:0] CTX_TEST_EXIT = 8'h00;

  // State commands and reports
  localparam logic [4:0] CTX_CMD_TX_START = 5'h02;
  localparam logic [4:0] CTX_CMD_OFF = 5'h03;
  localparam logic [4:0] CTX_CMD_PLL_ON = 5'h09;
  localparam logic [4:0] CTX_RPT_BUSY_TX = 5'h02;
  localparam logic [4:0] CTX_RPT_OFF = 5'h08;
  localparam logic [4:0] CTX_RPT_PLL_ON = 5'h09;
  localparam logic [4:0] CTX_RPT_TRANSITION = 5'h1F;

  // Interrupt bits, payload fill values, high rate select
  localparam int CTX_IRQ_PLL_LOCK = 0;
  localparam int CTX_IRQ_TX_END = 1;
  localparam logic [7:0] CTX_FILL_LOW = 8'h00;
  localparam logic [7:0] CTX_FILL_HIGH = 8'hFF;
  localparam logic [1:0] CTX_RATE_HIGH = 2'h3;

  typedef enum logic [1:0] {
    CTX_ST_OFF,
    CTX_ST_PLL_WAIT,
    CTX_ST_PLL_ON,
    CTX_ST_BUSY_TX
  } ctx_state_type;

endpackage

// ### ctx_bit_pacer.sv
// Bit pacer: shifts bytes out LSB first at the selected data rate.
// Assumes the byte on NEXT_BYTE stays stable until TAKE pulses.
`timescale 1ns/1ps
module ctx_bit_pacer
  import ctx_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic run,
  input wire logic [1:0] rate_sel,
  // Byte source
  input wire logic [7:0] next_byte,
  output logic take,
  // Bit output
  output logic bit_out,
  output logic bit_strobe
);

  typedef struct packed {
    logic run;
    logic [7:0] shift;
    logic [2:0] cnt;
    logic [5:0] div;
    logic bit_v;
    logic strobe;
  } ctx_pacer_type;

  ctx_pacer_type q, d;
  logic [5:0] limit;

  // Bit period for the chosen rate
  always_comb begin
    case (rate_sel)
      2'h0: limit = CTX_BIT_CYC0;
      2'h1: limit = CTX_BIT_CYC1;
      2'h2: limit = CTX_BIT_CYC2;
      default: limit = CTX_BIT_CYC3;
    endcase
  end

  // Byte loading and bit shifting
  always_comb begin
    d = q;
    take = 1'b0;
    d.strobe = 1'b0;
    d.run = run;
    if (!run) begin
      d.div = 6'h00;
      d.cnt = 3'h0;
    end else if (!q.run) begin
      d.shift = next_byte; // First byte of a burst
      take = 1'b1;
    end else if (q.div == limit - 6'h01) begin
      d.div = 6'h00;
      d.bit_v = q.shift[0];
      d.strobe = 1'b1;
      d.cnt = q.cnt + 3'h1;
      if (q.cnt == 3'h7) begin
        d.shift = next_byte;
        take = 1'b1;
      end else begin
        d.shift = {1'b0, q.shift[7:1]};
      end
    end else begin
      d.div = q.div + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bit_out = q.bit_v;
  assign bit_strobe = q.strobe;

endmodule

// ### ctx_rf_meter.sv
// Behavioural model of the RF test receiver watching the transmitter output.
// Assumes bit and strobe outputs are registered on the rising edge of clk.
`timescale 1ns/1ps
module ctx_rf_meter
  import ctx_pkg::*;
(
  // Clock
  input wire logic clk,
  // Transmitter output under measurement
  input wire logic tx_active,
  input wire logic tx_bit,
  input wire logic tx_bit_strobe
);
  logic [7:0] seen [0:15];
  logic [7:0] sh = 8'h00;
  int n_bytes = 0;
  int n_bits = 0;
  int cnt = 0;
  int gap = 0;

  // Rebuild bytes LSB first from the bit stream and time the bit period
  always @(posedge clk) begin
    cnt <= cnt + 1;
    if (!tx_active) begin
      n_bytes <= 0; // Each emission is captured from its first byte
      n_bits <= 0;
      cnt <= 0;
    end else if (tx_bit_strobe) begin
      gap <= cnt + 1;
      cnt <= 0;
      sh <= {tx_bit, sh[7:1]};
      if (n_bits == 7) begin
        if (n_bytes < 16) begin
          seen[n_bytes] <= {tx_bit, sh[7:1]};
        end
        n_bytes <= n_bytes + 1;
        n_bits <= 0;
      end else begin
        n_bits <= n_bits + 1;
      end
    end
  end
endmodule

// ### tb_ctx_continuous_tx.sv
// Self-checking bench for the continuous transmission test block.
// Assumes the register port of the design and the RF meter model beside it.
`timescale 1ns/1ps
module tb_ctx_continuous_tx;
  import ctx_pkg::*;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic WE = 1'b0;
  logic RE = 1'b0;
  logic [7:0] RDATA;
  logic IRQ, TX_ACTIVE, TX_BIT, TX_BIT_STROBE, TX_CW, TX_CW_UPPER, TEST_MODE;
  logic [7:0] TX_CHANNEL, TX_POWER;
  logic [7:0] d;
  logic [7:0] fills [0:2] = '{8'h00, 8'hFF, 8'h5A};
  int n_mismatch = 0;
  int n_compared = 0;

  ctx_continuous_tx DUT (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WE(WE),
    .RE(RE), .RDATA(RDATA), .IRQ(IRQ), .TX_ACTIVE(TX_ACTIVE), .TX_BIT(TX_BIT),
    .TX_BIT_STROBE(TX_BIT_STROBE), .TX_CW(TX_CW), .TX_CW_UPPER(TX_CW_UPPER),
    .TX_CHANNEL(TX_CHANNEL), .TX_POWER(TX_POWER), .TEST_MODE(TEST_MODE));
  ctx_rf_meter METER (.clk(CLK), .tx_active(TX_ACTIVE), .tx_bit(TX_BIT),
    .tx_bit_strobe(TX_BIT_STROBE));

  // Clock of 100 ns period
  initial begin
    forever #50 CLK = ~CLK;
  end

  task automatic conclude();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WE <= 1'b1;
    @(posedge CLK);
    WE <= 1'b0;
    #1; // Let the write take effect before any output is compared
  endtask

  // One-cycle read strobe; data taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    RE <= 1'b1;
    @(posedge CLK);
    RE <= 1'b0;
    #1 v = RDATA;
  endtask

  task automatic do_reset();
    @(posedge CLK);
    RESETN <= 1'b0;
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
  endtask

  // Bounded waits; an exhausted bound counts as a mismatch and ends the run
  task automatic wait_irq();
    int i;
    for (i = 0; i < 400 && IRQ !== 1'b1; i++) @(posedge CLK);
    if (IRQ !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
  endtask

  task automatic wait_bytes(input int n);
    int i;
    for (i = 0; i < 20000 && METER.n_bytes < n; i++) @(posedge CLK);
    if (METER.n_bytes < n) begin
      n_mismatch++;
      conclude();
    end
  endtask

  // Full programming sequence up to busy transmit
  task automatic run_mode(input logic [7:0] ctl2, input logic [7:0] len,
                          input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
    do_reset();
    wr(CTX_ADDR_IRQ_MASK, 8'h01);
    wr(CTX_ADDR_TX_CONTROL_ONE, 8'h00);
    wr(CTX_ADDR_STATE_COMMAND, 8'h03);
    wr(CTX_ADDR_CHANNEL_SELECT, 8'h33);
    wr(CTX_ADDR_OUTPUT_POWER, 8'h07);
    rd(CTX_ADDR_STATE_REPORT, d);
    check(d, 8'h08);
    wr(CTX_ADDR_TEST_CONTROL, 8'h0F);
    if (ctl2 != 8'h00) begin
      wr(CTX_ADDR_TRX_CONTROL_TWO, ctl2);
    end
    wr(8'h80, len);
    wr(8'h81, b1);
    wr(8'h82, b2);
    wr(8'h83, b3);
    wr(CTX_ADDR_PART_ID, 8'h54);
    wr(CTX_ADDR_PART_ID, 8'h46);
    check(TEST_MODE, 8'h01);
    check(TX_CHANNEL, 8'h33);
    check(TX_POWER, 8'h07);
    wr(CTX_ADDR_STATE_COMMAND, 8'h09);
    wait_irq();
    rd(CTX_ADDR_IRQ_STATUS, d);
    check(d, 8'h01);
    wr(CTX_ADDR_IRQ_STATUS, 8'h01);
    check(IRQ, 8'h00);
    rd(CTX_ADDR_STATE_REPORT, d);
    check(d, 8'h09);
    wr(CTX_ADDR_STATE_COMMAND, 8'h02);
    check(TX_ACTIVE, 8'h01);
  endtask

  // Main sequence
  initial begin
    int k;
    do_reset();
    check(TX_CHANNEL, 8'h2B);
    rd(CTX_ADDR_STATE_REPORT, d);
    check(d, 8'h08);
    rd(8'h7E, d);
    check(d, 8'h00);
    // Unlock out of order, start outside synthesizer-on, lock with mask clear
    wr(CTX_ADDR_TEST_CONTROL, 8'h0F);
    wr(CTX_ADDR_PART_ID, 8'h46);
    wr(CTX_ADDR_PART_ID, 8'h54);
    check(TEST_MODE, 8'h00);
    wr(CTX_ADDR_STATE_COMMAND, 8'h02);
    check(TX_ACTIVE, 8'h00);
    wr(CTX_ADDR_STATE_COMMAND, 8'h09);
    repeat (150) @(posedge CLK);
    check(IRQ, 8'h00);
    rd(CTX_ADDR_IRQ_STATUS, d);
    check(d, 8'h01);
    // Modulated pattern repeats payload without header or length byte
    run_mode(8'h00, 8'h03, 8'hA1, 8'h5C, 8'h3E);
    wait_bytes(7);
    for (k = 0; k < 7; k++) begin
      check(METER.seen[k], (k % 3 == 0) ? 8'hA1 : (k % 3 == 1) ? 8'h5C : 8'h3E);
    end
    check(8'(METER.gap), 8'h28);
    check(TX_CW, 8'h00);
    wr(CTX_ADDR_PART_ID, 8'h00);
    check(TEST_MODE, 8'h00);
    wr(CTX_ADDR_STATE_COMMAND, 8'h03);
    check(TX_ACTIVE, 8'h00);
    // Carrier fills at high rate: lower, upper, then a modulated byte
    for (k = 0; k < 3; k++) begin
      run_mode(8'h03, 8'h03, fills[k], fills[k], fills[k]);
      wait_bytes(4);
      check(METER.seen[3], fills[k]);
      check(8'(METER.gap), 8'h05);
      check(TX_CW, (k < 2) ? 8'h01 : 8'h00);
      check(TX_CW_UPPER, (k == 1) ? 8'h01 : 8'h00);
    end
    conclude();
  end
endmodule
